// >>> core/omc_clock_ctrl.sv
`timescale 1ns/1ns
module omc_clock_ctrl
    import omc_pkg::*;
(
    input logic sys_clk,
    input logic reset,
    input logic [1:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input logic haltReq,
    input logic wakeReq,
    input logic fastIsCrystal,
    input logic slowIsCrystal,
    input logic wdtEnabled,
    input logic wdtSrcIsSub,
    input logic fastOscTick,
    input logic slowOscTick,
    output omc_mode_e opMode,
    output logic cpuClkEn,
    output logic fastOscEn,
    output logic slowOscEn,
    output logic subClkEn,
    output logic wdtClkEn,
    output logic tbcClkEn,
    output logic wdtFuncEn,
    output omc_src_e sysClkSrc,
    output logic [2:0] sysDivShift
);

    // Divider code to shift count; zero for undivided or slow
    function automatic logic [2:0] div_shift(input logic fastSel, input logic [2:0] cks);
        logic [3:0] diff;
        diff = DIV_SHIFT_BASE - {1'b0, cks};
        if (fastSel || cks < CKS_FAST_MIN) begin
            return 3'h0;
        end
        return diff[2:0];
    endfunction : div_shift

    // Last tick index before an oscillator counts as stable
    function automatic logic [9:0] osc_last(input logic isXtal, input logic [10:0] rcCyc);
        logic [10:0] cyc;
        cyc = (isXtal ? XTAL_SETTLE_CYC : rcCyc) - 11'h001;
        return cyc[9:0];
    endfunction : osc_last

    omc_state_s st_q;
    omc_state_s st_d;
    logic runFast;
    logic sleep1Need;
    logic [7:0] modeReg;

    // Fast path wanted by the current select bits
    assign runFast = st_q.fastSel || st_q.cks >= CKS_FAST_MIN;
    // Something still needs the substitute clock while asleep
    assign sleep1Need = st_q.low_voltage_detect_enable || (wdtEnabled && wdtSrcIsSub);
    assign modeReg = {st_q.cks, st_q.quickWake, st_q.slowRdy, st_q.fastRdy, st_q.idleSel, st_q.fastSel};

    // Next-state logic for bus, flags, mode and clock gates
    always_comb begin
        st_d = st_q;

        // Bus answer: waitrequest drops one cycle after the request
        st_d.waitReq = 1'b1;
        if ((avs_read || avs_write) && st_q.waitReq) begin
            st_d.waitReq = 1'b0;
            case (avs_address)
                ADDR_MODE_CTRL: st_d.rdata = {24'h00_0000, modeReg};
                ADDR_AUX_CTRL: st_d.rdata = {30'h0000_0000, st_q.keepOn, st_q.low_voltage_detect_enable};
                ADDR_STATUS: st_d.rdata = {27'h000_0000, st_q.cpuEn, 1'b0, st_q.mode};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        // Writes land on the edge that completes the transfer
        if (avs_write && !st_q.waitReq && avs_byteenable[0]) begin
            case (avs_address)
                ADDR_MODE_CTRL: begin
                    st_d.cks = avs_writedata[CKS_MSB:CKS_LSB];
                    st_d.quickWake = avs_writedata[QUICK_BIT];
                    st_d.idleSel = avs_writedata[IDLE_SEL_BIT];
                    st_d.fastSel = avs_writedata[FAST_SEL_BIT];
                end
                ADDR_AUX_CTRL: begin
                    st_d.low_voltage_detect_enable = avs_writedata[LVD_BIT];
                    st_d.keepOn = avs_writedata[KEEP_ON_BIT];
                end
                default: ;
            endcase
        end

        // Fast ready: cleared while the oscillator is off, counts ticks when on
        if (!st_q.fastOscEn) begin
            st_d.fastCnt = 10'h000;
            st_d.fastRdy = 1'b0;
        end else if (!st_q.fastRdy && fastOscTick) begin
            if (st_q.fastCnt == osc_last(fastIsCrystal, FAST_RC_SETTLE_CYC)) begin
                st_d.fastRdy = 1'b1;
            end else begin
                st_d.fastCnt = st_q.fastCnt + 10'h001;
            end
        end
        // Slow ready: same scheme on the slow oscillator
        if (!st_q.slowOscEn) begin
            st_d.slowCnt = 10'h000;
            st_d.slowRdy = 1'b0;
        end else if (!st_q.slowRdy && slowOscTick) begin
            if (st_q.slowCnt == osc_last(slowIsCrystal, SLOW_RC_SETTLE_CYC)) begin
                st_d.slowRdy = 1'b1;
            end else begin
                st_d.slowCnt = st_q.slowCnt + 10'h001;
            end
        end

        // Substitute boot ends once the crystal is stable or the mode leaves normal
        if (st_q.fastRdy || st_q.mode != MD_NORMAL) begin
            st_d.subBoot = 1'b0;
        end

        // Mode sequencing
        case (st_q.mode)
            MD_NORMAL, MD_SLOW: begin
                if (haltReq) begin
                    if (!st_q.idleSel) begin
                        st_d.mode = sleep1Need ? MD_SLEEP1 : MD_SLEEP0;
                    end else begin
                        st_d.mode = st_q.keepOn ? MD_IDLE1 : MD_IDLE0;
                    end
                end else begin
                    st_d.mode = runFast ? MD_NORMAL : MD_SLOW;
                end
            end
            MD_IDLE0, MD_IDLE1, MD_SLEEP0, MD_SLEEP1: begin
                if (wakeReq) begin
                    st_d.mode = runFast ? MD_NORMAL : MD_SLOW;
                    // Substitute clock is dead after sleep0, so no quick wake then
                    if ((st_q.mode == MD_SLEEP1 || st_q.mode == MD_IDLE0) && runFast && st_q.quickWake
                        && fastIsCrystal && !st_q.fastRdy) begin
                        st_d.subBoot = 1'b1;
                    end
                end
            end
            default: st_d.mode = MD_NORMAL;
        endcase

        // Clock gates per mode; outputs are all registered copies
        st_d.divShift = div_shift(st_q.fastSel, st_q.cks);
        st_d.wdtFunc = wdtEnabled;
        st_d.cpuEn = 1'b0;
        st_d.src = SRC_OFF;
        st_d.fastOscEn = 1'b0;
        st_d.slowOscEn = 1'b1;
        st_d.subEn = 1'b1;
        st_d.wdtClk = 1'b1;
        st_d.tbcEn = 1'b1;
        case (st_d.mode)
            MD_NORMAL: begin
                // CPU waits for a stable oscillator unless booting on substitute
                st_d.fastOscEn = 1'b1;
                st_d.cpuEn = st_d.fastRdy || st_d.subBoot;
                if (st_d.fastRdy) begin
                    st_d.src = SRC_FAST;
                end else if (st_d.subBoot) begin
                    st_d.src = SRC_SUB;
                end
            end
            MD_SLOW: begin
                st_d.cpuEn = st_d.slowRdy;
                st_d.src = st_d.slowRdy ? SRC_SLOW : SRC_OFF;
            end
            MD_IDLE0: begin
                st_d.wdtClk = wdtSrcIsSub;
            end
            MD_IDLE1: begin
                st_d.fastOscEn = runFast;
                st_d.src = runFast ? SRC_FAST : SRC_SLOW;
            end
            MD_SLEEP0: begin
                st_d.slowOscEn = 1'b0;
                st_d.subEn = 1'b0;
                st_d.wdtClk = 1'b0;
                st_d.tbcEn = 1'b0;
                st_d.wdtFunc = 1'b0;
            end
            MD_SLEEP1: begin
                st_d.tbcEn = 1'b0;
            end
            default: ;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Ports straight from the state flops
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.waitReq;
    assign opMode = st_q.mode;
    assign cpuClkEn = st_q.cpuEn;
    assign fastOscEn = st_q.fastOscEn;
    assign slowOscEn = st_q.slowOscEn;
    assign subClkEn = st_q.subEn;
    assign wdtClkEn = st_q.wdtClk;
    assign tbcClkEn = st_q.tbcEn;
    assign wdtFuncEn = st_q.wdtFunc;
    assign sysClkSrc = st_q.src;
    assign sysDivShift = st_q.divShift;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Halt entry choices
    property p_sleep0_entry;
        (opMode == MD_NORMAL || opMode == MD_SLOW) && haltReq && !st_q.idleSel && !sleep1Need
            |=> opMode == MD_SLEEP0 ##1 !cpuClkEn && !subClkEn && !wdtClkEn && !wdtFuncEn;
    endproperty
    a_sleep0_entry: assert property (p_sleep0_entry) else $error("sleep0 entry or gating wrong");

    property p_sleep1_choice;
        (opMode == MD_NORMAL || opMode == MD_SLOW) && haltReq && !st_q.idleSel && sleep1Need
            |=> opMode == MD_SLEEP1 && subClkEn && wdtClkEn && !cpuClkEn;
    endproperty
    a_sleep1_choice: assert property (p_sleep1_choice) else $error("sleep1 not chosen");

    property p_idle_entry;
        (opMode == MD_NORMAL || opMode == MD_SLOW) && haltReq && st_q.idleSel
            |=> opMode == ($past(st_q.keepOn) ? MD_IDLE1 : MD_IDLE0);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

    property p_idle1_clocks;
        opMode == MD_IDLE1 |-> !cpuClkEn && sysClkSrc != SRC_OFF && wdtClkEn && tbcClkEn;
    endproperty
    a_idle1_clocks: assert property (p_idle1_clocks) else $error("idle1 clocks wrong");

    property p_idle0_wdt;
        opMode == MD_IDLE0 && $past(opMode) == MD_IDLE0
            |-> wdtClkEn == $past(wdtSrcIsSub) && sysClkSrc == SRC_OFF && !fastOscEn;
    endproperty
    a_idle0_wdt: assert property (p_idle0_wdt) else $error("idle0 watchdog clock wrong");

    property p_slow_fast_off;
        opMode == MD_SLOW |-> !fastOscEn && sysClkSrc != SRC_FAST;
    endproperty
    a_slow_fast_off: assert property (p_slow_fast_off) else $error("fast clock on in slow mode");

    property p_divider;
        opMode == MD_NORMAL && $past(opMode) == MD_NORMAL && !$past(st_q.fastSel)
            |-> sysDivShift == 3'(DIV_SHIFT_BASE - {1'b0, $past(st_q.cks)});
    endproperty
    a_divider: assert property (p_divider) else $error("divider ratio wrong");

    property p_fast_settle;
        $rose(st_q.fastRdy) |-> $past(st_q.fastCnt) == osc_last($past(fastIsCrystal), FAST_RC_SETTLE_CYC);
    endproperty
    a_fast_settle: assert property (p_fast_settle) else $error("fast ready too early");

    property p_slow_clear;
        opMode == MD_SLEEP0 ##1 opMode == MD_SLEEP0 |-> !st_q.slowRdy && !st_q.fastRdy;
    endproperty
    a_slow_clear: assert property (p_slow_clear) else $error("ready flag high in sleep0");

    property p_quick_wake;
        opMode == MD_NORMAL && st_q.subBoot && !st_q.fastRdy |-> cpuClkEn && sysClkSrc == SRC_SUB;
    endproperty
    a_quick_wake: assert property (p_quick_wake) else $error("quick wake not on substitute");

    // Detect enable keeps the substitute clock alive, so sleep0 is never chosen
    property p_lvd_blocks_sleep0;
        (opMode == MD_NORMAL || opMode == MD_SLOW) && haltReq && !st_q.idleSel && st_q.low_voltage_detect_enable
            |=> opMode == MD_SLEEP1;
    endproperty
    a_lvd_blocks_sleep0: assert property (p_lvd_blocks_sleep0) else $error("sleep0 entered with detect on");

    // Sleep1 gating: the substitute and watchdog clocks and the slow oscillator survive; CPU, time base and fast oscillator stop
    property p_sleep1_gates;
        opMode == MD_SLEEP1 |-> !cpuClkEn && subClkEn && wdtClkEn && !tbcClkEn && !fastOscEn;
    endproperty
    a_sleep1_gates: assert property (p_sleep1_gates) else $error("sleep1 gating wrong");

    // Running modes keep every peripheral clock on
    property p_running_clocks;
        (opMode == MD_NORMAL || opMode == MD_SLOW) |-> subClkEn && wdtClkEn && tbcClkEn;
    endproperty
    a_running_clocks: assert property (p_running_clocks) else $error("peripheral clock off while running");

    // No halted mode may clock the CPU
    property p_halted_cpu;
        !(opMode == MD_NORMAL || opMode == MD_SLOW) |-> !cpuClkEn;
    endproperty
    a_halted_cpu: assert property (p_halted_cpu) else $error("CPU clocked while halted");

    // Wake always lands in a running mode one cycle later
    property p_wake;
        !(opMode == MD_NORMAL || opMode == MD_SLOW) && wakeReq |=> opMode == MD_NORMAL || opMode == MD_SLOW;
    endproperty
    a_wake: assert property (p_wake) else $error("wake ignored");

    // Fast select bypasses the divider
    property p_fast_undivided;
        opMode == MD_NORMAL && $past(st_q.fastSel) |-> sysDivShift == 3'h0;
    endproperty
    a_fast_undivided: assert property (p_fast_undivided) else $error("fast clock divided");

    // Slow codes give no divided fast clock
    property p_slow_source;
        opMode == MD_SLOW |-> sysDivShift == 3'h0 && sysClkSrc != SRC_SUB;
    endproperty
    a_slow_source: assert property (p_slow_source) else $error("slow mode source wrong");

    // A stopped fast oscillator can never look ready
    property p_fast_ready_off;
        !$past(fastOscEn) |-> !st_q.fastRdy;
    endproperty
    a_fast_ready_off: assert property (p_fast_ready_off) else $error("fast ready with oscillator off");

    // Sleep0 also stops the slow oscillator and the time base
    property p_sleep0_slow_off;
        opMode == MD_SLEEP0 |-> !slowOscEn && !fastOscEn && !tbcClkEn;
    endproperty
    a_sleep0_slow_off: assert property (p_sleep0_slow_off) else $error("oscillator on in sleep0");

    // Stable crystal takes over from the substitute and ends the boot phase
    property p_quick_end;
        $rose(st_q.fastRdy) && opMode == MD_NORMAL |-> sysClkSrc == SRC_FAST && cpuClkEn ##1 !st_q.subBoot;
    endproperty
    a_quick_end: assert property (p_quick_end) else $error("no switch to crystal when ready");

endmodule : omc_clock_ctrl

// >>> core/omc_pkg.sv
package omc_pkg;

    // Operating modes reported on opMode
    typedef enum logic [2:0] {
        MD_NORMAL,
        MD_SLOW,
        MD_IDLE0,
        MD_IDLE1,
        MD_SLEEP0,
        MD_SLEEP1
    } omc_mode_e;

    // Source currently feeding the system clock
    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_FAST,
        SRC_SLOW,
        SRC_SUB
    } omc_src_e;

    // Register word addresses (word index in avs_address)
    localparam logic [1:0] ADDR_MODE_CTRL = 2'h0;
    localparam logic [1:0] ADDR_AUX_CTRL = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;

    // Mode control register fields
    localparam int CKS_MSB = 7;
    localparam int CKS_LSB = 5;
    localparam int QUICK_BIT = 4;
    localparam int IDLE_SEL_BIT = 1;
    localparam int FAST_SEL_BIT = 0;
    // Auxiliary control register fields
    localparam int LVD_BIT = 0;
    localparam int KEEP_ON_BIT = 1;

    // Divider codes: below 2 means slow clock, shift = 8 - code
    localparam logic [2:0] CKS_FAST_MIN = 3'h2;
    localparam logic [3:0] DIV_SHIFT_BASE = 4'h8;

    // Oscillator settle counts, in oscillator cycles
    localparam logic [10:0] XTAL_SETTLE_CYC = 11'h400;
    localparam logic [10:0] FAST_RC_SETTLE_CYC = 11'h010;
    localparam logic [10:0] SLOW_RC_SETTLE_CYC = 11'h002;

    // Whole state of the controller
    typedef struct packed {
        omc_mode_e mode;
        logic [2:0] cks;
        logic quickWake;
        logic slowRdy;
        logic fastRdy;
        logic idleSel;
        logic fastSel;
        logic low_voltage_detect_enable;
        logic keepOn;
        logic subBoot;
        logic [9:0] fastCnt;
        logic [9:0] slowCnt;
        logic waitReq;
        logic [31:0] rdata;
        logic cpuEn;
        logic fastOscEn;
        logic slowOscEn;
        logic subEn;
        logic wdtClk;
        logic tbcEn;
        logic wdtFunc;
        omc_src_e src;
        logic [2:0] divShift;
    } omc_state_s;

    localparam omc_state_s ST_RESET = '{
        mode: MD_NORMAL, cks: 3'h0, quickWake: 1'b0, slowRdy: 1'b0,
        fastRdy: 1'b0, idleSel: 1'b1, fastSel: 1'b1, low_voltage_detect_enable: 1'b0,
        keepOn: 1'b0, subBoot: 1'b0, fastCnt: 10'h000, slowCnt: 10'h000,
        waitReq: 1'b1, rdata: 32'h0000_0000, cpuEn: 1'b0, fastOscEn: 1'b1,
        slowOscEn: 1'b1, subEn: 1'b1, wdtClk: 1'b1, tbcEn: 1'b1,
        wdtFunc: 1'b0, src: SRC_OFF, divShift: 3'h0
    };

endpackage : omc_pkg

// >>> test/omc_clock_ctrl_tb_top.sv
`timescale 1ns/1ns
module omc_clock_ctrl_tb_top;
    import omc_pkg::*;
    logic sys_clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic haltReq, wakeReq, fastIsCrystal, slowIsCrystal, wdtEnabled, wdtSrcIsSub, slowPace, fastOscTick, slowOscTick;
    logic cpuClkEn, fastOscEn, slowOscEn, subClkEn, wdtClkEn, tbcClkEn, wdtFuncEn;
    logic [2:0] sysDivShift;
    omc_mode_e opMode;
    omc_src_e sysClkSrc;
    int mismatches, nTests;

    omc_clock_ctrl dut (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .haltReq(haltReq), .wakeReq(wakeReq),
        .fastIsCrystal(fastIsCrystal), .slowIsCrystal(slowIsCrystal), .wdtEnabled(wdtEnabled),
        .wdtSrcIsSub(wdtSrcIsSub), .fastOscTick(fastOscTick), .slowOscTick(slowOscTick), .opMode(opMode),
        .cpuClkEn(cpuClkEn),
        .fastOscEn(fastOscEn), .slowOscEn(slowOscEn), .subClkEn(subClkEn), .wdtClkEn(wdtClkEn),
        .tbcClkEn(tbcClkEn), .wdtFuncEn(wdtFuncEn), .sysClkSrc(sysClkSrc), .sysDivShift(sysDivShift));
    omc_osc_model osc (.sys_clk(sys_clk), .reset(reset), .fastOscEn(fastOscEn), .slowOscEn(slowOscEn),
        .slowPace(slowPace), .fastOscTick(fastOscTick), .slowOscTick(slowOscTick));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d, input logic be,
                       output logic [31:0] q);
        int i;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= {3'h7, be};
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            mismatches++;
            wrap_up();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Bounded wait for the CPU clock; running out counts as a mismatch
    task automatic wait_cpu;
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge sys_clk);
            if (cpuClkEn === 1'b1) break;
        end
        if (i == 3000) begin
            mismatches++;
            wrap_up();
        end
    endtask : wait_cpu

    task automatic sc_startup;
        logic [31:0] q;
        bus(1'b0, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        check(q, 32'h0000_0003);
        wait_cpu();
        check(sysClkSrc, SRC_FAST);
        check(sysDivShift, 3'h0);
        bus(1'b0, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        check(q, 32'h0000_000f);
        bus(1'b0, ADDR_AUX_CTRL, 8'h00, 1'b1, q);
        check(q, 32'h0000_0000);
        bus(1'b0, 2'h3, 8'h00, 1'b1, q);
        check(q, 32'h0000_0000);
        // Disabled lane and read-only flags must both leave the register alone
        bus(1'b1, ADDR_MODE_CTRL, 8'h00, 1'b0, q);
        bus(1'b1, ADDR_MODE_CTRL, 8'h03, 1'b1, q);
        bus(1'b0, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        check(q, 32'h0000_000f);
    endtask : sc_startup

    // Codes run downwards so that the fast clock is never re-started mid-loop
    task automatic sc_divider;
        logic [31:0] q;
        for (int c = 7; c >= 0; c--) begin
            bus(1'b1, ADDR_MODE_CTRL, {3'(c), 5'h02}, 1'b1, q);
            @(posedge sys_clk);
            wait_cpu();
            if (c >= 2) begin
                check({opMode, sysClkSrc, sysDivShift, fastOscEn}, {MD_NORMAL, SRC_FAST, 3'(8 - c), 1'b1});
            end else begin
                check({opMode, sysClkSrc, fastOscEn}, {MD_SLOW, SRC_SLOW, 1'b0});
            end
        end
        bus(1'b1, ADDR_MODE_CTRL, 8'h03, 1'b1, q);
        @(posedge sys_clk);
        wait_cpu();
        check({opMode, sysClkSrc, sysDivShift}, {MD_NORMAL, SRC_FAST, 3'h0});
    endtask : sc_divider

    task automatic sc_halt(input logic idle, input logic keep, input logic lvd, input logic wEn,
                           input logic wSub, input omc_mode_e m, input logic [3:0] g);
        logic [31:0] q;
        bus(1'b1, ADDR_AUX_CTRL, {6'h00, keep, lvd}, 1'b1, q);
        bus(1'b1, ADDR_MODE_CTRL, {6'h00, idle, 1'b1}, 1'b1, q);
        wdtEnabled <= wEn;
        wdtSrcIsSub <= wSub;
        @(posedge sys_clk) haltReq <= 1'b1;
        @(posedge sys_clk) haltReq <= 1'b0;
        @(posedge sys_clk);
        check(opMode, m);
        check(cpuClkEn, 1'b0);
        check({subClkEn, wdtClkEn, fastOscEn, tbcClkEn}, g);
        check(wdtFuncEn, wEn && m != MD_SLEEP0);
        check(slowOscEn, m != MD_SLEEP0);
        bus(1'b0, ADDR_STATUS, 8'h00, 1'b1, q);
        check(q[2:0], m);
        bus(1'b0, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        check(q[2], g[1]);
        if (m == MD_SLEEP0) check(q[3], 1'b0);
        @(posedge sys_clk) wakeReq <= 1'b1;
        @(posedge sys_clk) wakeReq <= 1'b0;
        wait_cpu();
        check(opMode, MD_NORMAL);
    endtask : sc_halt

    // Crystal wake from idle0 with quick wake: runs on the substitute clock first
    task automatic sc_quick;
        logic [31:0] q;
        int n;
        fastIsCrystal <= 1'b1;
        slowPace <= 1'b1;
        bus(1'b1, ADDR_AUX_CTRL, 8'h00, 1'b1, q);
        bus(1'b1, ADDR_MODE_CTRL, 8'h13, 1'b1, q);
        @(posedge sys_clk) haltReq <= 1'b1;
        @(posedge sys_clk) haltReq <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check(opMode, MD_IDLE0);
        @(posedge sys_clk) wakeReq <= 1'b1;
        @(posedge sys_clk) wakeReq <= 1'b0;
        wait_cpu();
        check(sysClkSrc, SRC_SUB);
        for (n = 0; n < 5000; n++) begin
            @(posedge sys_clk);
            if (sysClkSrc === SRC_FAST) break;
        end
        check(n >= 2000 && n < 5000, 1'b1);
        bus(1'b0, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        check(q[2], 1'b1);
    endtask : sc_quick

    // Watch crystal wake from sleep0 into slow mode; CPU waits for 1024 slow ticks
    task automatic sc_slow_xtal;
        logic [31:0] q;
        int n;
        slowIsCrystal <= 1'b1;
        bus(1'b1, ADDR_AUX_CTRL, 8'h00, 1'b1, q);
        bus(1'b1, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        wdtEnabled <= 1'b0;
        @(posedge sys_clk) haltReq <= 1'b1;
        @(posedge sys_clk) haltReq <= 1'b0;
        @(posedge sys_clk) wakeReq <= 1'b1;
        check(opMode, MD_SLEEP0);
        @(posedge sys_clk) wakeReq <= 1'b0;
        // Slow ticks come every fourth cycle, so the crystal settles after about 4096 edges
        for (n = 0; n < 6000; n++) begin
            @(posedge sys_clk);
            if (cpuClkEn === 1'b1) break;
        end
        check(n >= 4000 && n < 4200, 1'b1);
        check({opMode, sysClkSrc, fastOscEn}, {MD_SLOW, SRC_SLOW, 1'b0});
        bus(1'b0, ADDR_MODE_CTRL, 8'h00, 1'b1, q);
        check(q[3], 1'b1);
    endtask : sc_slow_xtal

    // Main sequence
    initial begin
        reset = 1'b1;
        avs_address = 2'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        haltReq = 1'b0;
        wakeReq = 1'b0;
        fastIsCrystal = 1'b0;
        slowIsCrystal = 1'b0;
        wdtEnabled = 1'b0;
        wdtSrcIsSub = 1'b0;
        slowPace = 1'b0;
        mismatches = 0;
        nTests = 0;
        repeat (8) @(posedge sys_clk);
        check({opMode, cpuClkEn, fastOscEn, sysClkSrc}, {MD_NORMAL, 1'b0, 1'b1, SRC_OFF});
        reset <= 1'b0;
        sc_startup();
        sc_divider();
        sc_halt(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, MD_SLEEP0, 4'h0);
        sc_halt(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, MD_SLEEP1, 4'hc);
        sc_halt(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, MD_SLEEP1, 4'hc);
        sc_halt(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, MD_IDLE0, 4'h9);
        sc_halt(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, MD_IDLE0, 4'hd);
        sc_halt(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, MD_IDLE1, 4'hf);
        sc_quick();
        sc_slow_xtal();
        wrap_up();
    end
endmodule : omc_clock_ctrl_tb_top

// >>> test/omc_osc_model.sv
`timescale 1ns/1ns
// Stand-in for the oscillators: one tick per oscillator cycle
module omc_osc_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic fastOscEn,
    input wire logic slowOscEn,
    input wire logic slowPace,
    output logic fastOscTick,
    output logic slowOscTick
);
    logic [1:0] phaseQ;
    // A stopped oscillator gives no edges, so ticks end as soon as it is disabled
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phaseQ <= 2'h0;
            fastOscTick <= 1'b0;
            slowOscTick <= 1'b0;
        end else begin
            phaseQ <= phaseQ + 2'h1;
            fastOscTick <= fastOscEn && (!slowPace || phaseQ[0]); // Half rate when pacing slowly
            slowOscTick <= slowOscEn && (phaseQ == 2'h3); // Slow oscillator at a quarter rate
        end
    end
endmodule : omc_osc_model
